// *** mrp_ctrl.sv ***
// register file and control logic of the microphone record path
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "mrp_cfg.svh"
// What this block does
// (R1) decode bias select, code zero reserved
// (R2) bias select changes only while bias off
// (R3) software disables bias before sleeping
// (R4) preamp enable and mute bits act
// (R5) preamp gain six dB steps from -6
// (R6) stage gain 1.5 dB steps from -4.5
// (R7) zero-cross sync defers gain to crossing
// (R8) no crossing in 100 ms applies gain
// (R9) ramp steps every code, beats zero-cross
// (R10) stage mute silences regardless of gain
// (R11) converter clock family follows sample rate
// (R12) 24-bit samples at selected rate
// (R13) converter enable runs or stops channel
// (R14) digital gain 0.75 dB steps to +12
// (R15) active digital gain readable during ramp
// (R16) digital gain ramps at selected rate
// (R17) high-pass on after reset, clear bypasses
// (R18) speech mode uses 3-bit corner
// (R19) music mode uses 2-bit corner
// (R20) music corner doubles per code step
// (R21) speech filter only up to 16 kHz
// (R22) new write restarts zero-cross timeout
// (R23) sleep halts everything until awake set
module mrp_ctrl #(
  parameter int ZC_TIMEOUT_CYC = `MRP_ZC_TMO_MS * `MRP_CLK_KHZ // 100 ms
) (
  input  wire logic                  ref_clk,      // 100 MHz core clock
  input  wire logic                  rst_b,        // async reset, low
  input  wire mrp_pkg::mrp_axi_req_t axi_req,      // axi4-lite requests
  output      mrp_pkg::mrp_axi_rsp_t axi_rsp,      // axi4-lite answers
  input  wire logic                  zc_pin,       // signal sign from analog
  input  wire logic [23:0]           adc_raw,      // raw converter word
  output      logic                  bias_on,      // bias regulator on
  output      logic                  bias_valid,   // select not reserved
  output      logic [11:0]           bias_mv,      // bias level in mV
  output      logic                  pre_on,       // preamp powered
  output      logic                  pre_mute,     // preamp silenced
  output      logic [7:0]            pre_gain_db,  // preamp gain, dB
  output      logic                  pga_on,       // gain stage powered
  output      logic                  pga_silent,   // gain stage silenced
  output      logic [3:0]            pga_gain,     // applied stage code
  output      logic [7:0]            pga_gain_hdb, // stage gain, half dB
  output      logic                  adc_run,      // converter running
  output      logic                  adc_fam_44k,  // 2.8224 MHz family
  output      logic [9:0]            dg_qdb,       // digital gain, 1/4 dB
  output      logic                  sample_stb,   // one-cycle sample mark
  output      logic [23:0]           sample,       // converter sample
  output      logic                  hpf_on,       // high-pass active
  output      logic                  hpf_speech,   // speech-mode filter
  output      logic [2:0]            hpf_corner    // corner code in use
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic                 aw_ok_q, w_ok_q, bvalid_q, rvalid_q; // bus flags
  logic [31:0]          awaddr_q, wdata_q, rdata_q;          // held words
  logic [3:0]           wstrb_q;                             // held strobes
  logic [1:0]           bresp_q, rresp_q;                    // responses
  logic                 awake_q;                             // system awake
  mrp_pkg::mrp_bias_t   bias_q;                              // bias control
  mrp_pkg::mrp_pre_t    pre_q;                               // preamp
  mrp_pkg::mrp_pga_t    pga_q;                               // stage target
  mrp_pkg::mrp_adc_t    adc_q;                               // converter
  mrp_pkg::mrp_dg_t     dg_q;                                // digital gain
  mrp_pkg::mrp_filt_t   filt_q;                              // filters
  mrp_pkg::mrp_pga_st_t pst_q;                               // stage fsm
  logic [3:0]           pga_act_q;                           // applied code
  logic [23:0]          zc_tmr_q;                            // zc timeout
  logic [11:0]          step_q;                              // ramp pacing
  logic [2:0]           zc_s_q;                              // sync + last
  logic [26:0]          acc_q;                               // rate phase
  logic                 stb_q;                               // sample mark
  logic [23:0]          smp_q;                               // sample out
  logic [6:0]           dg_act_q;                            // active gain
  logic [2:0]           dg_div_q;                            // ramp divider

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        do_wr = aw_ok_q & w_ok_q & wstrb_q[0];
  wire        wr_go = aw_ok_q & w_ok_q;
  wire [7:0]  wd    = wdata_q[7:0];
  wire        ar_hs = axi_req.arvalid & ~rvalid_q;
  wire        wr_sys  = do_wr & (awaddr_q == `MRP_A_SYS);
  wire        wr_bias = do_wr & (awaddr_q == `MRP_A_BIAS);
  wire        wr_pre  = do_wr & (awaddr_q == `MRP_A_PRE);
  wire        wr_pga  = do_wr & (awaddr_q == `MRP_A_PGA);
  wire        wr_adc  = do_wr & (awaddr_q == `MRP_A_ADC);
  wire        wr_dg   = do_wr & (awaddr_q == `MRP_A_DG);
  wire        wr_filt = do_wr & (awaddr_q == `MRP_A_FILT);
  wire        wr_map  = (awaddr_q[31:6] == 26'h0000000) &
                        (awaddr_q[1:0] == 2'h0) &
                        (awaddr_q <= `MRP_A_FILT);
  wire mrp_pkg::mrp_bias_t bias_w = mrp_pkg::mrp_bias_t'(wd[3:0]);
  wire mrp_pkg::mrp_adc_t  adc_w  = mrp_pkg::mrp_adc_t'(wd);
  // a bias write while running keeps the old level, enable still moves
  wire [2:0]  bias_sel_d = bias_q.en ? bias_q.sel : bias_w.sel; // see R2
  // unsupported rate codes leave the previous rate in place
  wire [3:0]  rate_d = (adc_w.rate > `MRP_SR_MAX) ? adc_q.rate : adc_w.rate;
  wire spch_blk = filt_q.speech & (adc_q.rate > `MRP_SR_16K); // see R21

  assign axi_rsp.awready = ~aw_ok_q & ~bvalid_q;
  assign axi_rsp.wready  = ~w_ok_q & ~bvalid_q;
  assign axi_rsp.bvalid  = bvalid_q;
  assign axi_rsp.bresp   = bresp_q;
  assign axi_rsp.arready = ~rvalid_q;
  assign axi_rsp.rvalid  = rvalid_q;
  assign axi_rsp.rdata   = rdata_q;
  assign axi_rsp.rresp   = rresp_q;

  // sample rate in hertz per rate code
  function automatic logic [16:0] rate_hz(input logic [3:0] c);
    case (c)
      4'h0:    rate_hz = 17'h01f40; // 8 kHz
      4'h1:    rate_hz = 17'h02b11; // 11.025 kHz
      4'h2:    rate_hz = 17'h02ee0; // 12 kHz
      4'h3:    rate_hz = 17'h03e80; // 16 kHz
      4'h4:    rate_hz = 17'h05622; // 22.05 kHz
      4'h5:    rate_hz = 17'h05dc0; // 24 kHz
      4'h6:    rate_hz = 17'h07d00; // 32 kHz
      4'h7:    rate_hz = 17'h0ac44; // 44.1 kHz
      4'h8:    rate_hz = 17'h0bb80; // 48 kHz
      4'h9:    rate_hz = 17'h15888; // 88.2 kHz
      default: rate_hz = 17'h17700; // 96 kHz
    endcase
  endfunction : rate_hz

  ////////////////////////////////////////////////////////////////////////
  // read mux, unmapped words read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (axi_req.araddr == `MRP_A_SYS) begin
      rd_mux[0] = awake_q;
    end else if (axi_req.araddr == `MRP_A_BIAS) begin
      rd_mux[3:0] = bias_q;
    end else if (axi_req.araddr == `MRP_A_PRE) begin
      rd_mux[4:0] = pre_q;
    end else if (axi_req.araddr == `MRP_A_PGA) begin
      rd_mux[7:0] = pga_q;
    end else if (axi_req.araddr == `MRP_A_PGA_ST) begin
      rd_mux[4:0] = {pst_q != mrp_pkg::PGA_IDLE, pga_act_q};
    end else if (axi_req.araddr == `MRP_A_ADC) begin
      rd_mux[7:0] = adc_q;
    end else if (axi_req.araddr == `MRP_A_DG) begin
      rd_mux[7:0] = dg_q;
    end else if (axi_req.araddr == `MRP_A_DG_ST) begin
      rd_mux[7:0] = {dg_act_q != dg_q.gain, dg_act_q}; // see R15
    end else if (axi_req.araddr == `MRP_A_FILT) begin
      rd_mux[7:0] = {spch_blk, filt_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_ok_q  <= 1'b0;
      w_ok_q   <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `MRP_RESP_OK;
      awaddr_q <= 32'h00000000;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else begin
      if (axi_req.awvalid & axi_rsp.awready) begin
        aw_ok_q  <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid & axi_rsp.wready) begin
        w_ok_q  <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      if (wr_go) begin // both halves held: commit and answer
        aw_ok_q  <= 1'b0;
        w_ok_q   <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? `MRP_RESP_OK : `MRP_RESP_ERR;
      end else if (bvalid_q & axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read path answers one cycle after the address is taken
  wire rd_map = (axi_req.araddr[31:6] == 26'h0000000) &
                (axi_req.araddr[1:0] == 2'h0) &
                (axi_req.araddr <= `MRP_A_FILT);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `MRP_RESP_OK;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_map ? `MRP_RESP_OK : `MRP_RESP_ERR;
    end else if (rvalid_q & axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awake_q <= 1'b0;
      bias_q  <= `MRP_BIAS_RST;
      pre_q   <= `MRP_PRE_RST;
      pga_q   <= `MRP_PGA_RST;
      adc_q   <= `MRP_ADC_RST;
      dg_q    <= `MRP_DG_RST;
      filt_q  <= `MRP_FILT_RST; // high-pass enabled from reset, see R17
    end else begin
      if (wr_sys)  awake_q <= wd[0];
      if (wr_bias) bias_q  <= {bias_w.en, bias_sel_d}; // see R2
      if (wr_pre)  pre_q   <= wd[4:0];
      if (wr_pga)  pga_q   <= wd;
      if (wr_adc)  adc_q   <= {adc_w.rrate, adc_w.ramp, rate_d, adc_w.en};
      if (wr_dg)   dg_q    <= wd;
      if (wr_filt) filt_q  <= wd[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // zero-cross input: two flops of sync, third holds the last level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      zc_s_q <= 3'h0;
    end else begin
      zc_s_q <= {zc_s_q[1:0], zc_pin};
    end
  end
  wire zc_edge = zc_s_q[2] ^ zc_s_q[1];

  // ramp pacing tick, held while asleep
  wire step_tick = (step_q == 12'h000);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      step_q <= `MRP_PGA_STEP_CY - 12'h001;
    end else if (awake_q) begin // see R23
      step_q <= step_tick ? `MRP_PGA_STEP_CY - 12'h001 : step_q - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gain stage update fsm: ramp wins over zero-cross, else direct
  localparam logic [23:0] ZC_LOAD = 24'(ZC_TIMEOUT_CYC - 1);
  wire pga_new = wr_pga & (wd[3:0] != pga_act_q);
  wire zc_fire = zc_edge | (zc_tmr_q == 24'h000000);
  wire ramp_up = pga_q.gain > pga_act_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_q     <= mrp_pkg::PGA_IDLE;
      pga_act_q <= 4'(`MRP_PGA_RST);
      zc_tmr_q  <= 24'h000000;
    end else if (awake_q) begin // see R23
      case (pst_q)
        mrp_pkg::PGA_IDLE: begin
          if (pga_new & wd[7]) begin
            pst_q <= mrp_pkg::PGA_RAMP; // see R9
          end else if (pga_new & wd[6]) begin
            pst_q    <= mrp_pkg::PGA_WAIT_ZC; // see R7
            zc_tmr_q <= ZC_LOAD;
          end else if (pga_new) begin
            pga_act_q <= wd[3:0];
          end
        end
        mrp_pkg::PGA_WAIT_ZC: begin
          if (wr_pga) begin
            zc_tmr_q <= ZC_LOAD; // latest value waits afresh, see R22
          end else if (zc_fire) begin
            pga_act_q <= pga_q.gain; // crossing or timeout, see R7 R8
            pst_q     <= mrp_pkg::PGA_IDLE;
          end else begin
            zc_tmr_q <= zc_tmr_q - 24'h000001;
          end
        end
        mrp_pkg::PGA_RAMP: begin
          if (pga_act_q == pga_q.gain) begin
            pst_q <= mrp_pkg::PGA_IDLE;
          end else if (step_tick) begin // one code per tick, see R9
            pga_act_q <= ramp_up ? pga_act_q + 4'h1 : pga_act_q - 4'h1;
          end
        end
        default: pst_q <= mrp_pkg::PGA_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample timing: exact fractional phase, no drift at 44.1 kHz family
  wire [26:0] acc_sum = acc_q + {10'h000, rate_hz(adc_q.rate)};
  wire        acc_wrap = acc_sum >= `MRP_CLK_HZ;
  wire        run = awake_q & adc_q.en; // see R13 R23
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= 27'h0000000;
      stb_q <= 1'b0;
      smp_q <= 24'h000000;
    end else begin
      acc_q <= !run ? 27'h0000000 :
               acc_wrap ? acc_sum - `MRP_CLK_HZ : acc_sum;
      stb_q <= run & acc_wrap; // see R12
      if (run & acc_wrap) smp_q <= dg_q.mute ? 24'h000000 : adc_raw;
    end
  end

  // digital gain: jump, or step once per 2^rate samples while ramping
  wire [2:0] dg_lim = 3'((4'h1 << adc_q.rrate) - 4'h1);
  wire       dg_step = stb_q & (dg_div_q >= dg_lim);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dg_act_q <= 7'(`MRP_DG_RST);
      dg_div_q <= 3'h0;
    end else if (awake_q) begin
      if (stb_q) dg_div_q <= dg_step ? 3'h0 : dg_div_q + 3'h1;
      if (!adc_q.ramp) begin
        dg_act_q <= dg_q.gain;
      end else if (dg_step & (dg_act_q < dg_q.gain)) begin
        dg_act_q <= dg_act_q + 7'h01; // see R16
      end else if (dg_step & (dg_act_q > dg_q.gain)) begin
        dg_act_q <= dg_act_q - 7'h01; // see R16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs: enables and sample mark forced off while asleep, mutes forced on, levels and codes not gated
  wire spch_on  = filt_q.speech & filt_q.hpf_en & ~spch_blk;  // see R18
  assign bias_valid = bias_q.sel != 3'h0; // see R1
  assign bias_on    = awake_q & bias_q.en & bias_valid;
  assign bias_mv    = !bias_valid ? 12'h000 :
                      (bias_q.sel == `MRP_BIAS_TOP) ? `MRP_BIAS_TOP_MV :
                      12'(bias_q.sel) * `MRP_BIAS_STEP + `MRP_BIAS_BASE;
  assign pre_on      = awake_q & pre_q.en; // see R4
  assign pre_mute    = pre_q.mute | ~pre_on; // see R4
  assign pre_gain_db = 8'(pre_q.gain) * `MRP_PRE_STEP + `MRP_PRE_MIN; // see R5
  assign pga_on       = awake_q & pga_q.en;
  assign pga_silent   = pga_q.mute | ~pga_on; // see R10
  assign pga_gain     = pga_act_q;
  assign pga_gain_hdb = 8'(pga_act_q) * `MRP_PGA_STEP + `MRP_PGA_MIN; // see R6
  assign adc_run      = run;
  // 1 selects 2.8224 MHz for the 11.025 kHz multiples, see R11
  assign adc_fam_44k  = (adc_q.rate == 4'h1) | (adc_q.rate == 4'h4) |
                        (adc_q.rate == 4'h7) | (adc_q.rate == 4'h9);
  assign dg_qdb     = 10'(dg_act_q) * `MRP_DG_STEP + `MRP_DG_MIN; // see R14
  assign sample_stb = stb_q & awake_q; // last mark dropped on sleep, see R23
  assign sample     = smp_q;
  assign hpf_on     = awake_q & filt_q.hpf_en; // see R17
  assign hpf_speech = awake_q & spch_on;
  // music corner code zero-extended to three bits, corner doubles per step, see R19 R20
  assign hpf_corner = spch_on ? filt_q.sp_corner : {1'b0, filt_q.mu_corner};

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence zc_wait_s;
    pst_q == mrp_pkg::PGA_WAIT_ZC && !zc_fire && !wr_pga;
  endsequence
  bias_lock_a: assert property (wr_bias && bias_q.en |=> // see R2
    $stable(bias_q.sel)) else $error("bias level moved while on");
  sleep_gate_a: assert property (!awake_q |-> // see R23
    !bias_on && !pre_on && !adc_run && !sample_stb)
    else $error("output active while asleep");
  zc_hold_a: assert property (zc_wait_s |=> // see R7
    $stable(pga_act_q)) else $error("stage gain moved before crossing");
  zc_tmo_a: assert property (awake_q && pst_q == mrp_pkg::PGA_WAIT_ZC && // see R8
    !wr_pga && zc_tmr_q == 24'h000000 |=> pga_act_q == $past(pga_q.gain))
    else $error("timeout did not apply gain");
  zc_restart_a: assert property (awake_q && wr_pga && // see R22
    pst_q == mrp_pkg::PGA_WAIT_ZC |=> zc_tmr_q == ZC_LOAD)
    else $error("timeout not restarted");
  pga_ramp_a: assert property (pst_q == mrp_pkg::PGA_RAMP |=> // see R9
    (pga_act_q - $past(pga_act_q) == 4'h1) ||
    ($past(pga_act_q) - pga_act_q == 4'h1) || $stable(pga_act_q))
    else $error("ramp skipped a code");
  pga_mute_a: assert property (pga_q.mute |-> pga_silent) // see R10
    else $error("stage not silenced");
  dg_ramp_a: assert property (adc_q.ramp && $changed(dg_act_q) && // see R16
    $past(adc_q.ramp) |-> $past(stb_q))
    else $error("digital gain moved off a step");
  speech_lim_a: assert property (adc_q.rate > `MRP_SR_16K |-> // see R21
    !hpf_speech) else $error("speech filter above 16 kHz");
  stb_single_a: assert property (stb_q |=> !stb_q) // see R12
    else $error("sample mark longer than a cycle");

endmodule : mrp_ctrl

// *** mrp_cfg.svh ***
// constants for the microphone record path control block
`ifndef MRP_CFG_SVH
`define MRP_CFG_SVH
`define MRP_CLK_HZ      27'h5f5e100
`define MRP_CLK_KHZ     24'h0186a0
`define MRP_ZC_TMO_MS   24'h000064
`define MRP_PGA_STEP_CY 12'h3e8
`define MRP_A_SYS       32'h00000000
`define MRP_A_BIAS      32'h00000004
`define MRP_A_PRE       32'h00000008
`define MRP_A_PGA       32'h0000000c
`define MRP_A_PGA_ST    32'h00000010
`define MRP_A_ADC       32'h00000014
`define MRP_A_DG        32'h00000018
`define MRP_A_DG_ST     32'h0000001c
`define MRP_A_FILT      32'h00000020
`define MRP_BIAS_RST    4'h1
`define MRP_PRE_RST     5'h00
`define MRP_PGA_RST     8'h03
`define MRP_ADC_RST     8'h10
`define MRP_DG_RST      8'h6f
`define MRP_FILT_RST    7'h01
`define MRP_BIAS_TOP    3'h7
`define MRP_BIAS_TOP_MV 12'hb54
`define MRP_BIAS_STEP   12'h0c8
`define MRP_BIAS_BASE   12'h640
`define MRP_PRE_STEP    8'h06
`define MRP_PRE_MIN     8'hfa
`define MRP_PGA_STEP    8'h03
`define MRP_PGA_MIN     8'hf7
`define MRP_DG_STEP     10'h003
`define MRP_DG_MIN      10'h2b3
`define MRP_SR_16K      4'h3
`define MRP_SR_MAX      4'ha
`define MRP_RESP_OK     2'h0
`define MRP_RESP_ERR    2'h2
`endif

// *** mrp_pkg.sv ***
// types shared by the microphone record path control block
package mrp_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } mrp_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mrp_axi_rsp_t;
  typedef struct packed {
    logic       en;
    logic [2:0] sel;
  } mrp_bias_t;
  typedef struct packed {
    logic [2:0] gain;
    logic       mute;
    logic       en;
  } mrp_pre_t;
  typedef struct packed {
    logic       ramp;
    logic       zc;
    logic       mute;
    logic       en;
    logic [3:0] gain;
  } mrp_pga_t;
  typedef struct packed {
    logic [1:0] rrate;
    logic       ramp;
    logic [3:0] rate;
    logic       en;
  } mrp_adc_t;
  typedef struct packed {
    logic       mute;
    logic [6:0] gain;
  } mrp_dg_t;
  typedef struct packed {
    logic [2:0] sp_corner;
    logic [1:0] mu_corner;
    logic       speech;
    logic       hpf_en;
  } mrp_filt_t;
  typedef enum logic [1:0] {PGA_IDLE, PGA_WAIT_ZC, PGA_RAMP} mrp_pga_st_t;
endpackage : mrp_pkg

// *** mrp_ctrl_tb.sv ***
// self-checking bench for the record path control block
`timescale 1ns/100ps
module mic_record_path_control_tb;
  logic                  ref_clk;   // core clock
  logic                  rst_b;     // reset, low
  mrp_pkg::mrp_axi_req_t req;       // bus requests
  mrp_pkg::mrp_axi_rsp_t rsp;       // bus answers
  logic                  zc_pin;    // zero-cross input
  logic [23:0]           adc_raw;   // raw converter word
  logic [23:0]           smp;       // converter sample
  logic bias_on, bias_valid, pre_on, pre_mute, pga_on, pga_silent;
  logic adc_run, fam, stb, hpf_on, hpf_speech;
  logic [11:0]           bias_mv;   // bias level
  logic [7:0]            pre_db;    // preamp gain
  logic [3:0]            pga_gain;  // applied stage code
  logic [7:0]            pga_hdb;   // stage gain
  logic [9:0]            dg_qdb;    // digital gain
  logic [2:0]            corner;    // filter corner
  logic [31:0]           d;         // last read data
  logic [1:0]            resp;      // last response
  logic [7:0]            e8;        // expected byte
  int                    errors, comparisons, n, c, cnt;
  // short timeout count keeps the zero-cross test brief
  mrp_ctrl #(.ZC_TIMEOUT_CYC(200)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
    .zc_pin(zc_pin), .adc_raw(adc_raw), .bias_on(bias_on),
    .bias_valid(bias_valid), .bias_mv(bias_mv), .pre_on(pre_on),
    .pre_mute(pre_mute), .pre_gain_db(pre_db), .pga_on(pga_on),
    .pga_silent(pga_silent), .pga_gain(pga_gain), .pga_gain_hdb(pga_hdb),
    .adc_run(adc_run), .adc_fam_44k(fam), .dg_qdb(dg_qdb),
    .sample_stb(stb), .sample(smp), .hpf_on(hpf_on),
    .hpf_speech(hpf_speech), .hpf_corner(corner));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task results;
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // a wait that ran out counts as a mismatch and ends the run
  task lim(input int k);
    if (k >= 200) begin
      errors++;
      results();
    end
  endtask : lim
  // ready is sampled mid-cycle, so the handshake edge is the next rise
  task wr(input logic [31:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw, bv;
    int   k;
    @(posedge ref_clk);
    req.awaddr  <= a;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    bv = 1'b0;
    for (k = 0; k < 200 && !bv; k++) begin
      @(negedge ref_clk);
      ta = pa & rsp.awready;
      tw = pw & rsp.wready;
      bv = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge ref_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      pa = pa & !ta;
      pw = pw & !tw;
    end
    req.bready <= 1'b0;
    lim(bv ? 0 : k);
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [31:0] a);
    logic pa, ta, rv;
    int   k;
    @(posedge ref_clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    pa = 1'b1;
    rv = 1'b0;
    for (k = 0; k < 200 && !rv; k++) begin
      @(negedge ref_clk);
      ta = pa & rsp.arready;
      rv = rsp.rvalid;
      d = rsp.rdata;
      resp = rsp.rresp;
      @(posedge ref_clk);
      if (ta) req.arvalid <= 1'b0;
      pa = pa & !ta;
    end
    req.rready <= 1'b0;
    lim(rv ? 0 : k);
    @(negedge ref_clk);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    req = '0;
    zc_pin = 1'b0;
    adc_raw = 24'h5a5a5a;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(32'h20);
    chk("filt reset", d, 32'h01);
    rd(32'h24);
    chk("bad addr resp", resp, 32'h2);
    chk("bad addr data", d, 32'h0);
    wr(32'h00, 32'h01);
    for (c = 1; c < 8; c++) begin
      wr(32'h04, c);
      cnt = (c == 7) ? 32'hb54 : 32'h708 + 32'hc8 * (c - 1);
      chk("bias mv", bias_mv, cnt);
    end
    wr(32'h04, 32'h00);
    chk("bias valid", bias_valid, 32'h0);
    wr(32'h04, 32'h0b);
    wr(32'h04, 32'h0d);
    chk("bias locked", bias_mv, 32'h898);
    chk("bias on", bias_on, 32'h1);
    for (c = 0; c < 8; c++) begin
      wr(32'h08, c * 4 + 1);
      e8 = 8'(6 * c - 6);
      chk("pre gain", pre_db, e8);
    end
    wr(32'h08, 32'h03);
    chk("pre on", pre_on, 32'h1);
    chk("pre mute", pre_mute, 32'h1);
    for (c = 0; c < 16; c++) begin
      wr(32'h0c, 32'h10 | c);
      e8 = 8'(3 * c - 9);
      chk("pga gain", pga_hdb, e8);
    end
    wr(32'h0c, 32'h3f);
    chk("pga mute", pga_silent, 32'h1);
    // zero-cross: held until the pin moves, then by timeout
    wr(32'h0c, 32'h59);
    repeat (3) @(negedge ref_clk);
    chk("zc held", pga_gain, 32'hf);
    @(posedge ref_clk);
    zc_pin <= 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("zc applied", pga_gain, 32'h9);
    wr(32'h0c, 32'h5c);
    repeat (100) @(negedge ref_clk);
    wr(32'h0c, 32'h5d);
    repeat (150) @(negedge ref_clk);
    chk("zc restart", pga_gain, 32'h9);
    repeat (100) @(negedge ref_clk);
    chk("zc timeout", pga_gain, 32'hd);
    // ramp with zero-cross also set: must climb one code at a time
    wr(32'h0c, 32'hdf);
    c = 13;
    for (n = 0; n < 3000; n++) begin
      @(negedge ref_clk);
      if (pga_gain !== c[3:0]) begin
        chk("ramp step", pga_gain, c + 1);
        c = c + 1;
      end
    end
    chk("ramp end", pga_gain, 32'hf);
    for (c = 0; c < 11; c++) begin
      wr(32'h14, c * 2 + 1);
      chk("clk family", fam, (c == 1 || c == 4 || c == 7 || c == 9));
      chk("adc run", adc_run, 32'h1);
    end
    wr(32'h14, 32'h11);
    cnt = 0;
    for (n = 0; n < 20833; n++) begin
      @(negedge ref_clk);
      cnt = cnt + stb;
      if (stb) chk("sample", smp, 32'h5a5a5a);
    end
    chk("strobes", (cnt >= 9 && cnt <= 11), 32'h1);
    wr(32'h18, 32'h7f);
    chk("dg gain", dg_qdb, 32'h030);
    rd(32'h1c);
    chk("dg status", d, 32'h7f);
    wr(32'h18, 32'hff);
    for (n = 0; n < 3000 && !stb; n++) @(negedge ref_clk);
    lim(stb ? 0 : 200);
    chk("muted sample", smp, 32'h0);
    wr(32'h14, 32'h35);
    wr(32'h18, 32'h6f);
    rd(32'h1c);
    chk("dg ramping", d[7], 32'h1);
    wr(32'h14, 32'h06);
    chk("adc stop", adc_run, 32'h0);
    wr(32'h20, 32'h09);
    chk("music mode", hpf_speech, 32'h0);
    chk("music corner", corner, 32'h2);
    wr(32'h20, 32'h53);
    chk("speech mode", hpf_speech, 32'h1);
    chk("speech corner", corner, 32'h5);
    wr(32'h14, 32'h11);
    chk("speech fast", hpf_speech, 32'h0);
    rd(32'h20);
    chk("speech flag", d[7], 32'h1);
    wr(32'h20, 32'h00);
    chk("hpf bypass", hpf_on, 32'h0);
    wr(32'h04, 32'h03); // bias off before sleep
    wr(32'h00, 32'h00);
    chk("sleep adc", adc_run, 32'h0);
    chk("sleep pre", pre_on, 32'h0);
    chk("sleep pga", pga_on, 32'h0);
    results();
  end
endmodule : mic_record_path_control_tb
